// ### common/intc_pkg.sv
package intc_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC = 16;            // user interrupt sources
    localparam int NUM_TRAP = 4;            // trap sources
    localparam int SRC_IDX_W = 4;           // index width for sources
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS = 12'h000;   // status readback, read only
    localparam logic [11:0] OFS_CTRL1 = 12'h004;    // nesting disable + trap flags
    localparam logic [11:0] OFS_FLAG = 12'h008;     // source flags, w1c
    localparam logic [11:0] OFS_ENABLE = 12'h00C;   // source enables
    localparam logic [11:0] OFS_PRIO_LO = 12'h010;  // priorities of sources 0..7
    localparam logic [11:0] OFS_PRIO_HI = 12'h014;  // priorities of sources 8..15
    localparam logic [11:0] OFS_CPU_LEVEL = 12'h018; // status low byte, level in 7:5
    localparam logic [11:0] OFS_TIMED_DIS = 12'h01C; // timed disable cycle count
    localparam logic [11:0] OFS_CMD = 12'h020;      // bit0 take, bit1 return
    localparam logic [11:0] OFS_IRQ_STAT = 12'h024; // sticky event status, w1c
    localparam logic [11:0] OFS_IRQ_MASK = 12'h028; // interrupt mask
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_LEVEL = 8;           // level field in status readback
    localparam int POS_NEST_DIS = 15;       // nesting disable in ctrl1
    localparam int POS_CPU_LVL = 5;         // level bits in status low byte
    localparam int PRIO_W = 3;              // per source priority width
    localparam int POS_CMD_RET = 1;         // return command bit
    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [2:0] PRIO_RESET = 3'h4;    // every source starts at level 4
    localparam logic [3:0] LVL_USER_MAX = 4'h7;  // top user level
    localparam logic [3:0] LVL_TRAP_BASE = 4'h8; // first trap level
    localparam logic [6:0] VEC_OFFSET = 7'h08;   // field value = vector - 8
    localparam logic [6:0] VEC_USER_BASE = 7'h0C;// vector of source 0 minus 8
    localparam int DEPTH = 4;                    // saved level stack depth
    localparam int IRQ_W = 2;                    // bit0 vector taken, bit1 trap raised
endpackage

// ### rtl/intc_pick.sv
`timescale 1ns/1ps
// lowest index among the highest priority eligible sources
module intc_pick
    import intc_pkg::*;
(
    // candidates
    input wire logic [NUM_SRC-1:0] elig,
    input wire logic [NUM_SRC*PRIO_W-1:0] prio,
    // winner
    output logic found,
    output logic [SRC_IDX_W-1:0] idx,
    output logic [PRIO_W-1:0] best
);
    // ------------------------------------------------------------
    // scan from high index down so ties go to the lowest index
    // equal priorities everywhere degrade to a plain fixed order
    // ------------------------------------------------------------
    always_comb begin
        found = 1'b0;
        idx = '0;
        best = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (elig[i] && prio[i*PRIO_W +: PRIO_W] >= best) begin
                found = 1'b1;
                idx = SRC_IDX_W'(i);
                best = prio[i*PRIO_W +: PRIO_W];
            end
        end
    end
endmodule

// ### rtl/intc_core.sv
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module intc_core
    import intc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event inputs
    input wire logic [NUM_SRC-1:0] src_event,
    input wire logic [NUM_TRAP-1:0] trap_event,
    // to processor
    output logic req_valid,
    output logic [6:0] req_vector,
    output logic irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] prdata;                    // read data
        logic pready;                           // access answer
        logic pslverr;                          // unmapped address
        logic nest_dis;                         // nesting disable
        logic [NUM_TRAP-1:0] trap_flag;         // trap status flags
        logic [NUM_SRC-1:0] flag;               // source flags
        logic [NUM_SRC-1:0] enable;             // source enables
        logic [NUM_SRC*PRIO_W-1:0] prio;        // source priorities
        logic [3:0] level;                      // cpu priority level
        logic [15:0] tdis_cnt;                  // timed disable remaining
        logic [DEPTH*4-1:0] stack;              // saved levels
        logic [2:0] sp;                         // stack depth in use
        logic [IRQ_W-1:0] irq_stat;             // sticky events
        logic [IRQ_W-1:0] irq_mask;             // event mask
        logic req_valid;                        // request shown
        logic [6:0] req_vector;                 // pending vector field
        logic irq;                              // interrupt output
    } state_s;

    state_s cur, next_cur;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] elig;     // sources allowed to request
    logic found;
    logic [SRC_IDX_W-1:0] win_idx;
    logic [PRIO_W-1:0] win_prio;
    logic trap_any;
    logic [1:0] trap_idx;
    logic in_service;             // a routine is running

    assign in_service = cur.sp != 3'h0;

    // per source eligibility, one generate loop
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : gen_elig
            logic [PRIO_W-1:0] p;
            assign p = cur.prio[g*PRIO_W +: PRIO_W];
            // flag held set keeps the request alive; enable gates it
            assign elig[g] = cur.flag[g] && cur.enable[g] && p != '0
                && {1'b0, p} > cur.level
                && !(cur.tdis_cnt != '0 && {1'b0, p} != LVL_USER_MAX)
                && !(cur.nest_dis && in_service);
        end
    endgenerate

    intc_pick u_pick (
        .elig(elig),
        .prio(cur.prio),
        .found(found),
        .idx(win_idx),
        .best(win_prio)
    );

    // traps pass only while their level, 8 plus index, is above the cpu level; nesting disable does not hold them
    always_comb begin
        trap_any = 1'b0;
        trap_idx = '0;
        for (int i = NUM_TRAP - 1; i >= 0; i--) begin
            if (cur.trap_flag[i] && {2'b0, i[1:0]} + LVL_TRAP_BASE > cur.level) begin
                trap_any = 1'b1;
                trap_idx = i[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic wr, rd;
    logic [IRQ_W-1:0] ev;
    assign wr = psel && penable && pwrite && !cur.pready;
    assign rd = psel && penable && !pwrite && !cur.pready;

    always_comb begin
        next_cur = cur;
        ev = '0;
        next_cur.pready = psel && penable && !cur.pready;
        next_cur.pslverr = 1'b0;
        // timed disable countdown
        if (cur.tdis_cnt != '0) begin
            next_cur.tdis_cnt = cur.tdis_cnt - 16'h0001;
        end
        // status readback fields
        if (trap_any) begin
            next_cur.req_valid = 1'b1;
            next_cur.req_vector = {5'h0, trap_idx}; // traps take low vectors
        end else if (found) begin
            next_cur.req_valid = 1'b1;
            next_cur.req_vector = VEC_USER_BASE + {3'h0, win_idx};
        end else begin
            next_cur.req_valid = 1'b0;
            next_cur.req_vector = '0;
        end
        // register writes, flag clears first so new events win
        if (wr) begin
            unique case (paddr)
                OFS_CTRL1: begin
                    next_cur.nest_dis = pwdata[POS_NEST_DIS];
                    next_cur.trap_flag = cur.trap_flag & ~pwdata[NUM_TRAP-1:0];
                end
                OFS_FLAG: next_cur.flag = cur.flag & ~pwdata[NUM_SRC-1:0];
                OFS_ENABLE: next_cur.enable = pwdata[NUM_SRC-1:0];
                OFS_PRIO_LO: next_cur.prio[23:0] = pwdata[23:0];
                OFS_PRIO_HI: next_cur.prio[47:24] = pwdata[23:0];
                // a pushed status restored by pop lands here
                OFS_CPU_LEVEL: next_cur.level = {1'b0, pwdata[POS_CPU_LVL +: 3]};
                OFS_TIMED_DIS: next_cur.tdis_cnt = pwdata[15:0];
                OFS_CMD: begin
                    if (pwdata[0] && cur.req_valid && cur.sp != 3'(DEPTH)) begin
                        // accept the shown vector: save level, raise it
                        next_cur.stack = {cur.stack[DEPTH*4-5:0], cur.level};
                        next_cur.sp = cur.sp + 3'h1;
                        next_cur.level = trap_any ? {2'b0, trap_idx} + LVL_TRAP_BASE
                            : {1'b0, win_prio};
                        ev[0] = 1'b1;
                    end else if (pwdata[POS_CMD_RET] && cur.sp != 3'h0) begin
                        next_cur.level = cur.stack[3:0];
                        next_cur.stack = {4'h0, cur.stack[DEPTH*4-1:4]};
                        next_cur.sp = cur.sp - 3'h1;
                    end
                end
                OFS_IRQ_STAT: next_cur.irq_stat = cur.irq_stat & ~pwdata[IRQ_W-1:0];
                OFS_IRQ_MASK: next_cur.irq_mask = pwdata[IRQ_W-1:0];
                default: next_cur.pslverr = !(paddr == OFS_STATUS);
            endcase
        end
        // events set flags after clears
        next_cur.flag = next_cur.flag | src_event;
        next_cur.trap_flag = next_cur.trap_flag | trap_event;
        ev[1] = |trap_event;
        next_cur.irq_stat = next_cur.irq_stat | ev;
        next_cur.irq = |(next_cur.irq_stat & next_cur.irq_mask);
        // read mux
        if (rd) begin
            next_cur.prdata = '0;
            unique case (paddr)
                OFS_STATUS: next_cur.prdata = {16'h0, 4'h0, cur.level, 1'b0, cur.req_vector};
                OFS_CTRL1: next_cur.prdata = {16'h0, cur.nest_dis, 11'h0, cur.trap_flag};
                OFS_FLAG: next_cur.prdata = {16'h0, cur.flag};
                OFS_ENABLE: next_cur.prdata = {16'h0, cur.enable};
                OFS_PRIO_LO: next_cur.prdata = {8'h0, cur.prio[23:0]};
                OFS_PRIO_HI: next_cur.prdata = {8'h0, cur.prio[47:24]};
                OFS_CPU_LEVEL: next_cur.prdata = {24'h0, cur.level[2:0], 5'h0};
                OFS_TIMED_DIS: next_cur.prdata = {16'h0, cur.tdis_cnt};
                OFS_CMD: next_cur.prdata = {29'h0, cur.sp};
                OFS_IRQ_STAT: next_cur.prdata = {30'h0, cur.irq_stat};
                OFS_IRQ_MASK: next_cur.prdata = {30'h0, cur.irq_mask};
                default: next_cur.pslverr = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cur <= '0;
            cur.prio <= {NUM_SRC{PRIO_RESET}};
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign req_valid = cur.req_valid;
    assign req_vector = cur.req_vector;
    assign irq = cur.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_level_blocks_user: assert property (@(posedge clk) disable iff (reset)
        (cur.level >= LVL_USER_MAX && !trap_any) |=> !req_valid)
        else $error("user request shown at level seven");
    chk_enable_gates: assert property (@(posedge clk) disable iff (reset)
        found |-> cur.enable[win_idx])
        else $error("disabled source won");
    chk_above_level: assert property (@(posedge clk) disable iff (reset)
        found |-> {1'b0, win_prio} > cur.level)
        else $error("winner not above cpu level");
    chk_tdis_holds: assert property (@(posedge clk) disable iff (reset)
        (cur.tdis_cnt != '0 && found) |-> win_prio == 3'h7)
        else $error("low level passed timed disable");
    chk_trap_wins: assert property (@(posedge clk) disable iff (reset)
        (cur.trap_flag[NUM_TRAP-1] && cur.level < 4'hB) |=> req_valid)
        else $error("trap masked by level");
    chk_nest_off: assert property (@(posedge clk) disable iff (reset)
        (cur.nest_dis && in_service) |-> !found)
        else $error("preemption with nesting disabled");
    chk_flag_sticks: assert property (@(posedge clk) disable iff (reset)
        (src_event[0]) |=> cur.flag[0])
        else $error("event lost on clear");
    chk_vec_status: assert property (@(posedge clk) disable iff (reset)
        (rd && paddr == OFS_STATUS) |=> prdata[6:0] == $past(cur.req_vector))
        else $error("status vector mismatch");
endmodule

// ### testbench/cpu_model.sv
`timescale 1ns/1ps
// processor side: latches every vector it sees offered
module cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // offered request
    input wire logic req_valid,
    input wire logic [6:0] req_vector,
    // what the core saw
    output logic [6:0] last_vec,
    output logic [7:0] offers
);
    // ------------------------------------------------------------
    // capture
    // ------------------------------------------------------------
    // the core only samples; it never acknowledges on its own
    always_ff @(posedge clk) begin
        if (reset) begin
            last_vec <= 7'h00;
            offers <= 8'h00;
        end else if (req_valid) begin
            last_vec <= req_vector;
            offers <= offers + 8'h01;
        end
    end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import intc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, req_valid, irq, err;
    logic [6:0] req_vector, last_vec;
    logic [7:0] offers;
    logic [NUM_SRC-1:0] src_event = '0;
    logic [NUM_TRAP-1:0] trap_event = '0;
    logic [31:0] rnd = 32'h72DC; // random state
    logic [23:0] pr; // low priority word
    int err_count = 0, comparisons = 0;
    always #2.5 clk = ~clk;
    intc_core intc_core_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_event(src_event), .trap_event(trap_event), .req_valid(req_valid), .req_vector(req_vector),
        .irq(irq));
    cpu_model cpu_model_i (.clk(clk), .reset(reset), .req_valid(req_valid), .req_vector(req_vector),
        .last_vec(last_vec), .offers(offers));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // expected {valid, vector} for sources 0..7 above a level
    function logic [7:0] pick(input logic [23:0] p, input logic [7:0] fl, input logic [3:0] lvl);
        logic [3:0] best;
        logic [7:0] r;
        best = lvl;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            // strictly greater keeps the lowest index on a tie
            if (fl[i] && {1'b0, p[3*i+:3]} > best && p[3*i+:3] != 3'h0) begin
                best = {1'b0, p[3*i+:3]};
                r = {1'b1, VEC_USER_BASE + 7'(i)};
            end
        end
        return r;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; waits on pready, no fixed latency assumed
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    // one cycle event pulse, then let flag and request settle
    task ev(input logic [NUM_SRC-1:0] s, input logic [NUM_TRAP-1:0] t);
        src_event <= s;
        trap_event <= t;
        @(posedge clk);
        src_event <= '0;
        trap_event <= '0;
        repeat (3) @(posedge clk);
    endtask
    task req(input logic [7:0] e);
        chk({req_valid, req_valid ? req_vector : 7'h00}, e);
    endtask
    task stop_test;
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        apb(0, OFS_PRIO_LO, 0); chk(rd[23:0], 24'h924924);
        apb(0, OFS_STATUS, 0); chk(rd, 32'h0);
        apb(0, 12'h030, 0); chk(err, 1); // unmapped
        apb(1, OFS_ENABLE, 32'h00FF);
        // random priorities and flag sets, first pass single level
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            pr = (k == 0) ? 24'h924924 : rnd[23:0];
            apb(1, OFS_PRIO_LO, {8'h00, pr});
            rnd = lfsr(rnd);
            ev({8'h00, rnd[7:0]}, 4'h0);
            req(pick(pr, rnd[7:0], 4'h0));
            apb(0, OFS_STATUS, 0);
            if (pick(pr, rnd[7:0], 4'h0) !== 8'h00) chk(rd, {25'h0, pick(pr, rnd[7:0], 4'h0) & 8'h7F});
            apb(1, OFS_FLAG, 32'hFFFF);
            repeat (2) @(posedge clk);
            req(8'h00);
        end
        apb(1, OFS_PRIO_LO, 32'h924924);
        ev(16'h0200, 4'h0); req(8'h00);
        ev(16'h0008, 4'h0); req(8'h8F);
        chk(last_vec, 7'h0F);
        chk(offers !== 8'h00, 1);
        // take it: level rises to 4, same priority no longer presented
        apb(1, OFS_CMD, 32'h1); repeat (2) @(posedge clk);
        apb(0, OFS_STATUS, 0); chk(rd[11:8], 4'h4);
        req(8'h00);
        apb(1, OFS_CMD, 32'h2); repeat (2) @(posedge clk);
        req(8'h8F);
        // level seven masks users, not traps
        apb(1, OFS_CPU_LEVEL, 32'hE0); repeat (2) @(posedge clk);
        req(8'h00);
        ev(16'h0, 4'h1); req(8'h80);
        apb(1, OFS_CTRL1, 32'hF);
        apb(1, OFS_CPU_LEVEL, 32'h0); repeat (2) @(posedge clk);
        req(8'h8F);
        apb(1, OFS_FLAG, 32'hFFFF);
        // timed disable passes only level seven
        apb(1, OFS_PRIO_LO, 32'h924927);
        apb(1, OFS_TIMED_DIS, 32'd30);
        ev(16'h0002, 4'h0); req(8'h00);
        ev(16'h0001, 4'h0); req(8'h8C);
        apb(1, OFS_FLAG, 32'h1);
        repeat (40) @(posedge clk);
        req(8'h8D);
        apb(1, OFS_CMD, 32'h1);
        // in service at level 4 with nesting off: level 7 must wait
        apb(1, OFS_CTRL1, 32'h8000);
        ev(16'h0001, 4'h0); req(8'h00);
        apb(1, OFS_CMD, 32'h2); repeat (2) @(posedge clk);
        req(8'h8C);
        apb(1, OFS_FLAG, 32'hFFFF);
        apb(1, OFS_CTRL1, 32'h0);
        // interrupt: raise, mask, clear
        apb(1, OFS_IRQ_STAT, 32'h3);
        apb(1, OFS_IRQ_MASK, 32'h1);
        ev(16'h0, 4'hA); chk(irq, 0);
        apb(1, OFS_IRQ_MASK, 32'h2); repeat (2) @(posedge clk);
        chk(irq, 1);
        apb(1, OFS_CTRL1, 32'hF);
        apb(1, OFS_IRQ_STAT, 32'h2); repeat (2) @(posedge clk);
        chk(irq, 0);
        stop_test();
    end
endmodule
